// ===== src/pm_event_saver.sv
// Contract
// - Send a PME message upstream when a power state change is requested; the code sends it only when secondary_pme_request_n is sampled low.
// - Never send PME while in the unpowered off state.
// - No beacon or sideband wake; PME travels only in-band.
// - PME goes as a posted TLP routed to the root complex.
// - Return the link to L0 before transmitting PME.
// - Sample secondary_pme_request_n every 100 microseconds.
// - In hot low-power, L0 only while sending PME or turn-off ack; the code also holds L0 while tx_pending is set.
// - In L2/L3 ready the PCI bus is down and PME is ignored.
// - Hot low-power: keep the fifth clock running, hold reset off, no bus cycles.
// - D0 with traffic or no policy: L0, all clocks running; the code stays in L0s if the policy is cleared there without traffic.
// - D0, L0s policy, idle: link L0s, clocks running.
// - D0, L1 policy, idle: link L1, core clock gated.
// - Hot low-power, no gating: L1, core clock gated, PCI clocks on.
// - Hot low-power with gating: L1, core and four PCI clocks gated.
// - Enter L0s after 6 us without transmit; leave on pending traffic.
// - Enter L1 after 10 us with nothing pending.
// - Entering hot low-power starts L1 entry on the upstream link.
`timescale 1ns/1ps
`default_nettype none
module pm_event_saver (
    input  wire logic                               sys_clk,
    input  wire logic                               nrst,
    input  wire pm_pkg::pm_cfg_s                    cfg,
    input  wire pm_pkg::link_status_s               link_st,
    input  wire logic                               secondary_pme_request_n,
    output pm_pkg::link_req_s                       link_req,
    output logic                                    pme_msg_valid,
    output logic                                    pme_ack_valid,
    output logic                                    core_clock_en,
    output logic [pm_pkg::SEC_CLK_ALL_W-1:0]        secondary_clock_en,
    output logic                                    secondary_bus_reset_n,
    output logic                                    secondary_bus_enable,
    output pm_pkg::link_state_e                     link_state
);
    pm_pkg::link_state_e state_r;
    pm_pkg::link_state_e state_nxt;

    logic                     pme_s1_r;
    logic                     pme_s2_r;
    logic                     pme_pend_r;
    logic                     ack_pend_r;
    logic                     sample_tick;
    logic [pm_pkg::CNT_W-1:0] idle_cnt_r;
    logic                     in_d0;
    logic                     in_hot;
    logic                     l0s_ok;
    logic                     l1_ok;
    logic                     gate_sec;
    logic                     need_l0;

    assign in_d0  = (cfg.power_state == pm_pkg::DSTATE_D0);
    assign in_hot = (cfg.power_state == pm_pkg::DSTATE_HOT);
    assign l0s_ok = cfg.link_power_policy_ctl[pm_pkg::POLICY_L0S_BIT];
    assign l1_ok  = cfg.link_power_policy_ctl[pm_pkg::POLICY_L1_BIT];

    pm_periodic_tick u_tick (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .tick    (sample_tick)
    );

    // Pin comes from the secondary bus, so synchronise first
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pme_s1_r <= 1'b1;
            pme_s2_r <= 1'b1;
        end else begin
            pme_s1_r <= secondary_pme_request_n;
            pme_s2_r <= pme_s1_r;
        end
    end

    // latch request on sample; dropped in L2/L3 ready
    // off state has no supply, so nothing here runs there
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pme_pend_r <= 1'b0;
        end else if (state_r == pm_pkg::LINK_L23) begin
            pme_pend_r <= 1'b0;
        end else if (sample_tick && !pme_s2_r) begin
            // Set wins over the clear below
            pme_pend_r <= 1'b1;
        end else if (pme_msg_valid && link_st.msg_ready) begin
            pme_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ack_pend_r <= 1'b0;
        end else if (state_r == pm_pkg::LINK_L23) begin
            // A held request cannot re-arm the ack while in L2/L3 ready
            ack_pend_r <= 1'b0;
        end else if (cfg.turn_off_req) begin
            ack_pend_r <= 1'b1;
        end else if (pme_ack_valid && link_st.msg_ready) begin
            ack_pend_r <= 1'b0;
        end
    end

    // idle time since last pending transmit
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            idle_cnt_r <= '0;
        end else if (need_l0 || !in_d0) begin
            // Messages count as traffic, so they restart the idle time
            idle_cnt_r <= '0;
        end else if (idle_cnt_r != {pm_pkg::CNT_W{1'b1}}) begin
            idle_cnt_r <= idle_cnt_r + 1'b1;
        end
    end

    assign need_l0 = pme_pend_r || ack_pend_r || link_st.tx_pending;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            pm_pkg::LINK_L0: begin
                if (ack_pend_r && pme_ack_valid && link_st.msg_ready) begin
                    state_nxt = pm_pkg::LINK_L23;
                end else if (need_l0) begin
                    state_nxt = pm_pkg::LINK_L0;
                end else if (in_hot) begin
                    state_nxt = pm_pkg::LINK_L1;
                end else if (l1_ok && idle_cnt_r >=
                             pm_pkg::CNT_W'(pm_pkg::L1_IDLE_CYC)) begin
                    state_nxt = pm_pkg::LINK_L1;
                end else if (l0s_ok && idle_cnt_r >=
                             pm_pkg::CNT_W'(pm_pkg::L0S_IDLE_CYC)) begin
                    state_nxt = pm_pkg::LINK_L0S;
                end
            end
            pm_pkg::LINK_L0S: begin
                // leave on pending; deepen to L1
                if (need_l0 || in_hot) begin
                    state_nxt = pm_pkg::LINK_WAKE;
                end else if (l1_ok && idle_cnt_r >=
                             pm_pkg::CNT_W'(pm_pkg::L1_IDLE_CYC)) begin
                    state_nxt = pm_pkg::LINK_L1;
                end
            end
            pm_pkg::LINK_L1: begin
                // wake the link for PME or ack
                if (need_l0 || (in_d0 && !l1_ok)) begin
                    state_nxt = pm_pkg::LINK_WAKE;
                end
            end
            pm_pkg::LINK_WAKE: begin
                // clocks already restored in this state
                if (link_st.link_in_l0) begin
                    state_nxt = pm_pkg::LINK_L0;
                end
            end
            pm_pkg::LINK_L23: begin
                if (in_d0) begin
                    state_nxt = pm_pkg::LINK_WAKE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= pm_pkg::LINK_L0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign link_state = state_r;

    always_comb begin
        link_req.req_l0  = (state_r == pm_pkg::LINK_WAKE);
        link_req.req_l0s = (state_r == pm_pkg::LINK_L0S);
        link_req.req_l1  = (state_r == pm_pkg::LINK_L1);
        link_req.req_l23 = (state_r == pm_pkg::LINK_L23);
    end

    // posted PME only once the link is in L0; no sideband
    assign pme_msg_valid = pme_pend_r && state_r == pm_pkg::LINK_L0 &&
                           link_st.link_in_l0;
    // ack goes after any pending PME
    assign pme_ack_valid = ack_pend_r && !pme_pend_r &&
                           state_r == pm_pkg::LINK_L0 && link_st.link_in_l0;

    // low four PCI clocks gated only in hot state with gating enabled, while the link rests in L1
    assign gate_sec = in_hot && cfg.secondary_clock_gate_enable &&
                      state_r == pm_pkg::LINK_L1 && !need_l0;

    // Registered enables avoid glitches on the clock gate controls
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            core_clock_en      <= 1'b1;
            secondary_clock_en <= '1;
        end else begin
            // clocks back on as soon as the link leaves L1
            core_clock_en <= !(state_nxt == pm_pkg::LINK_L1 && !need_l0);
            // only the low four clocks are ever gated
            secondary_clock_en <= {1'b1,
                {pm_pkg::SEC_CLK_GATED_W{!gate_sec}}};
        end
    end

    // reset held off in hot state; bus idle in L2/L3 ready
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            secondary_bus_reset_n <= 1'b0;
            secondary_bus_enable  <= 1'b0;
        end else begin
            secondary_bus_reset_n <= 1'b1;
            secondary_bus_enable  <= in_d0 && core_clock_en &&
                                     state_r != pm_pkg::LINK_L23;
        end
    end
endmodule
`default_nettype wire

// ===== shared/pm_pkg.sv
package pm_pkg;

    // Timing, in nanoseconds, and derived counts at the core clock rate
    localparam int unsigned CLK_PERIOD_NS   = 5;
    localparam int unsigned PME_SAMPLE_NS   = 100000;
    localparam int unsigned L0S_IDLE_NS     = 6000;
    localparam int unsigned L1_IDLE_NS      = 10000;
    localparam int unsigned PME_SAMPLE_CYC  = PME_SAMPLE_NS / CLK_PERIOD_NS;
    localparam int unsigned L0S_IDLE_CYC    =
        (L0S_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned L1_IDLE_CYC     =
        (L1_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W           = 16;

    localparam int unsigned SEC_CLK_ALL_W   = 5;
    localparam int unsigned SEC_CLK_GATED_W = 4;

    // Device power state encoding
    localparam logic [1:0] DSTATE_D0        = 2'h0;
    localparam logic [1:0] DSTATE_HOT       = 2'h3;

    // Link power policy field
    localparam int unsigned POLICY_L0S_BIT  = 0;
    localparam int unsigned POLICY_L1_BIT   = 1;

    typedef enum logic [4:0] {
        LINK_L0    = 5'h01,
        LINK_L0S   = 5'h02,
        LINK_L1    = 5'h04,
        LINK_L23   = 5'h08,
        LINK_WAKE  = 5'h10
    } link_state_e;

    // Controls from configuration space
    typedef struct packed {
        logic [1:0] power_state;
        logic [1:0] link_power_policy_ctl;
        logic       secondary_clock_gate_enable;
        logic       turn_off_req;
    } pm_cfg_s;

    // Link handshake toward the physical layer
    typedef struct packed {
        logic       tx_pending;
        logic       link_in_l0;
        logic       msg_ready;
    } link_status_s;

    typedef struct packed {
        logic       req_l0;
        logic       req_l0s;
        logic       req_l1;
        logic       req_l23;
    } link_req_s;

endpackage

// ===== src/pm_periodic_tick.sv
`timescale 1ns/1ps
`default_nettype none
module pm_periodic_tick (
    input  wire logic sys_clk,
    input  wire logic nrst,
    output logic      tick
);
    logic [pm_pkg::CNT_W-1:0] cnt_r;
    localparam logic [pm_pkg::CNT_W-1:0] LAST =
        pm_pkg::CNT_W'(pm_pkg::PME_SAMPLE_CYC - 1);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
        end else if (cnt_r == LAST) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign tick = (cnt_r == LAST);
endmodule
`default_nettype wire

// ===== verif/pm_event_saver_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pm_event_saver_chk (
    input wire logic                 sys_clk,
    input wire logic                 nrst,
    input wire pm_pkg::pm_cfg_s      cfg,
    input wire pm_pkg::link_status_s link_st,
    input wire logic                 secondary_pme_request_n,
    input wire pm_pkg::link_req_s    link_req,
    input wire logic                 pme_msg_valid,
    input wire logic                 pme_ack_valid,
    input wire logic                 core_clock_en,
    input wire logic [4:0]           secondary_clock_en,
    input wire logic                 secondary_bus_reset_n,
    input wire logic                 secondary_bus_enable,
    input wire pm_pkg::link_state_e  link_state
);
    localparam int unsigned L0S_MAX = pm_pkg::L0S_IDLE_CYC + 4;
    logic [15:0] idle_r;
    logic        hot;
    assign hot = cfg.power_state == pm_pkg::DSTATE_HOT;
    // Idle run that should end in standby
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            idle_r <= '0;
        else if (!hot && cfg.link_power_policy_ctl == 2'h1
                 && !link_st.tx_pending && link_state == pm_pkg::LINK_L0
                 && !pme_msg_valid && !pme_ack_valid)
            idle_r <= idle_r + 16'h1;
        else
            idle_r <= '0;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_pme_in_l0: assert property (pme_msg_valid |-> link_st.link_in_l0
        && link_state == pm_pkg::LINK_L0) else $error("pme outside L0");
    a_pme_holds: assert property (pme_msg_valid && !link_st.msg_ready
        |=> pme_msg_valid) else $error("pme dropped early");
    a_l23_quiet: assert property (link_state == pm_pkg::LINK_L23
        |-> !pme_msg_valid) else $error("pme in L2/L3");
    a_l0s_clocks: assert property (link_state == pm_pkg::LINK_L0S
        |-> core_clock_en && secondary_clock_en == 5'h1f)
        else $error("l0s gated");
    a_l1_gated: assert property ((link_state == pm_pkg::LINK_L1) [*2]
        |-> !core_clock_en) else $error("core clock runs in L1");
    a_hot_gate: assert property ((hot && cfg.secondary_clock_gate_enable
        && link_state == pm_pkg::LINK_L1) [*3] |-> secondary_clock_en == 5'h10)
        else $error("pci clocks not gated");
    a_hot_bus: assert property (hot [*3] |-> !secondary_bus_enable
        && secondary_clock_en[4] && secondary_bus_reset_n)
        else $error("hot bus");
    a_wake_clock: assert property ($rose(pme_msg_valid)
        |-> core_clock_en) else $error("pme with core clock gated");
    a_l0s_late: assert property (idle_r <= L0S_MAX)
        else $error("standby entry late");
    a_l0s_early: assert property (link_state == pm_pkg::LINK_L0S
        && $past(link_state) == pm_pkg::LINK_L0 |-> $past(idle_r) + 4
        >= pm_pkg::L0S_IDLE_CYC) else $error("standby entry early");
endmodule
bind pm_event_saver pm_event_saver_chk i_chk (.sys_clk(sys_clk), .nrst(nrst),
    .cfg(cfg), .link_st(link_st), .link_req(link_req),
    .secondary_pme_request_n(secondary_pme_request_n),
    .pme_msg_valid(pme_msg_valid), .pme_ack_valid(pme_ack_valid),
    .core_clock_en(core_clock_en), .secondary_clock_en(secondary_clock_en),
    .secondary_bus_reset_n(secondary_bus_reset_n),
    .secondary_bus_enable(secondary_bus_enable), .link_state(link_state));
`default_nettype wire

// ===== verif/pm_link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pm_link_partner (
    input wire logic              sys_clk,
    input wire logic              nrst,
    input wire logic              slow,
    input wire pm_pkg::link_req_s link_req,
    input wire logic              msg_valid,
    output logic                  link_in_l0,
    output logic                  msg_ready
);
    logic [3:0] lat;
    logic [3:0] l0_cnt_r;
    logic [3:0] m_cnt_r;
    assign lat = slow ? 4'hc : 4'h2;
    // Retraining takes time, so an eager sender is caught
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            l0_cnt_r <= '0;
            link_in_l0 <= 1'b1;
        end else if (link_req.req_l0s || link_req.req_l1 ||
                     link_req.req_l23) begin
            l0_cnt_r <= '0;
            link_in_l0 <= 1'b0;
        end else if (link_req.req_l0 && !link_in_l0) begin
            l0_cnt_r <= l0_cnt_r + 4'h1;
            link_in_l0 <= l0_cnt_r == lat;
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            m_cnt_r <= '0;
            msg_ready <= 1'b0;
        end else if (msg_ready || !(msg_valid && link_in_l0)) begin
            m_cnt_r <= '0;
            msg_ready <= 1'b0;
        end else begin
            m_cnt_r <= m_cnt_r + 4'h1;
            msg_ready <= m_cnt_r == lat;
        end
    end
endmodule
`default_nettype wire

// ===== verif/tb_pm_event_saver.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pm_event_saver;
    logic                 sys_clk = 1'b0;
    logic                 nrst = 1'b0;
    pm_pkg::pm_cfg_s      cfg = '0;
    logic                 tx = 1'b0;
    logic                 pin_n = 1'b1;
    logic                 slow = 1'b0;
    logic                 in_l0, rdy, pme_v, ack_v, core_en, rst_n, bus_en;
    logic [4:0]           sec_en;
    pm_pkg::link_req_s    req;
    pm_pkg::link_state_e  st;
    pm_pkg::link_status_s lst;
    int                   n_fail = 0;
    int                   tests_run = 0;
    int                   n;
    logic [1:0]           exp_q[$];
    always #2.5 sys_clk = ~sys_clk;
    assign lst = '{tx_pending: tx, link_in_l0: in_l0, msg_ready: rdy};
    pm_event_saver i_dut (.sys_clk(sys_clk), .nrst(nrst), .cfg(cfg),
        .link_st(lst), .secondary_pme_request_n(pin_n), .link_req(req),
        .pme_msg_valid(pme_v), .pme_ack_valid(ack_v), .core_clock_en(core_en),
        .secondary_clock_en(sec_en), .secondary_bus_reset_n(rst_n),
        .secondary_bus_enable(bus_en), .link_state(st));
    pm_link_partner i_far (.sys_clk(sys_clk), .nrst(nrst), .slow(slow),
        .link_req(req), .msg_valid(pme_v || ack_v), .link_in_l0(in_l0),
        .msg_ready(rdy));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d failures=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_st(input pm_pkg::link_state_e s, input int lim);
        n = 0;
        while (st !== s) begin
            if (n == lim) begin
                n_fail++;
                close_out();
            end
            cyc(1);
            n++;
        end
    endtask
    // Each accepted message must match the oldest note
    always @(negedge sys_clk) begin
        if (nrst && (pme_v || ack_v) && rdy) begin
            if (exp_q.size() == 0)
                chk(8'({ack_v, pme_v}), 8'h0);
            else
                chk(8'({ack_v, pme_v}), 8'(exp_q.pop_front()));
        end
    end
    initial begin
        void'($urandom(23426));
        cyc(5);
        nrst = 1'b1;
        tx = 1'b1;
        cfg.link_power_policy_ctl = 2'($urandom);
        cyc(2100);
        chk(8'(st), 8'(pm_pkg::LINK_L0));
        cfg.link_power_policy_ctl = 2'h0;
        tx = 1'b0;
        cyc(2100);
        chk(8'({core_en, sec_en, st == pm_pkg::LINK_L0}), 8'h7f);
        chk(8'({rst_n, bus_en}), 8'h3);
        tx = 1'b1;
        cyc(4);
        tx = 1'b0;
        cfg.link_power_policy_ctl = 2'h1;
        wait_st(pm_pkg::LINK_L0S, 1300);
        chk(8'(n + 4 >= pm_pkg::L0S_IDLE_CYC), 8'h1);
        chk(8'({core_en, sec_en}), 8'h3f);
        tx = 1'b1;
        cyc(40);
        chk(8'(st == pm_pkg::LINK_L0S), 8'h0);
        tx = 1'b0;
        cfg.link_power_policy_ctl = 2'h2;
        wait_st(pm_pkg::LINK_L1, 2100);
        chk(8'(n + 4 >= pm_pkg::L1_IDLE_CYC), 8'h1);
        cyc(2);
        chk(8'({core_en, sec_en}), 8'h1f);
        slow = 1'b1;
        pin_n = 1'b0;
        exp_q.push_back(2'h1);
        n = 0;
        while (pme_v !== 1'b1) begin
            if (n == 21000) begin
                n_fail++;
                close_out();
            end
            cyc(1);
            n++;
        end
        chk(8'({st == pm_pkg::LINK_L0, core_en}), 8'h3);
        cyc(30);
        pin_n = 1'b1;
        slow = 1'b0;
        chk(8'(exp_q.size()), 8'h0);
        cfg.power_state = pm_pkg::DSTATE_HOT;
        wait_st(pm_pkg::LINK_L1, 2100);
        cyc(4);
        chk(8'({core_en, sec_en}), 8'h1f);
        chk(8'({rst_n, bus_en}), 8'h2);
        cfg.secondary_clock_gate_enable = 1'b1;
        cyc(4);
        chk(8'({core_en, sec_en}), 8'h10);
        cfg.turn_off_req = 1'b1;
        exp_q.push_back(2'h2);
        wait_st(pm_pkg::LINK_L23, 400);
        cfg.turn_off_req = 1'b0;
        chk(8'(exp_q.size()), 8'h0);
        pin_n = 1'b0;
        cyc(20100);
        chk(8'(st), 8'(pm_pkg::LINK_L23));
        pin_n = 1'b1;
        cfg.power_state = pm_pkg::DSTATE_D0;
        cfg.secondary_clock_gate_enable = 1'b0;
        wait_st(pm_pkg::LINK_L0, 400);
        cyc(2);
        chk(8'({core_en, sec_en}), 8'h3f);
        close_out();
    end
endmodule
`default_nettype wire
